/* rtl/ccrb_pkg.sv */
// Package with layout, constants and carriers of the codec control register bank
// Contract
// - Global power bit powers all sections (the code does not apply it to reference output or five volt mode)
// - Power bit 1 powers analog gain tap
// - Power bit 2 powers input amplifier
// - Power bit 3 powers the ADC
// - Power bit 4 powers the DAC
// - Power bit 5 powers the reference
// - Power bit 6 enables reference output
// - Power bit 7 selects five volt mode
// - Gain bit 7 mutes the output
// - Gain bits 2..0 select input gain
// - Gain bits 6..4 select output gain
// - Mode bits 6..4 give cascade count
// - Clock bits 6..4 divide master clock
// - Timing bits 4..0 set DAC advance
// - Timing bit 5 bypasses the interpolator
// - Timing bit 6 enables digital gain tap
// - Either reset clears all; software reset takes four cycles
// - Clock bits 1..0 pick sample divider
// - DAC advance steps of period/32
// - Three-bit field selects target register
package ccrb_pkg;

  // Register indices within the bank
  localparam logic [2:0] OPERATING_MODE_CONTROL   = 3'h0;
  localparam logic [2:0] CLOCK_RATE_CONTROL       = 3'h1;
  localparam logic [2:0] POWER_CONTROL            = 3'h2;
  localparam logic [2:0] GAIN_CONTROL             = 3'h3;
  localparam logic [2:0] CONVERTER_TIMING_CONTROL = 3'h4;
  localparam int         NUM_REGS                 = 5;

  // Reset values and write masks
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] MODE_WR_MASK   = 8'h7f;
  localparam logic [7:0] TIMING_WR_MASK = 8'h7f;
  localparam logic [7:0] FULL_WR_MASK   = 8'hff;

  // Field positions
  localparam int MODE_SEL_BIT    = 0;
  localparam int MIXED_BIT       = 1;
  localparam int DLOOP_BIT       = 2;
  localparam int SLOOP_BIT       = 3;
  localparam int CASCADE_LSB     = 4;
  localparam int SOFT_RESET_BIT  = 7;
  localparam int RATE_LSB        = 0;
  localparam int SCLK_LSB        = 2;
  localparam int MCLK_LSB        = 4;
  localparam int ECHO_BIT        = 7;
  localparam int PWR_GLOBAL_BIT  = 0;
  localparam int PWR_AGT_BIT     = 1;
  localparam int PWR_IA_BIT      = 2;
  localparam int PWR_ADC_BIT     = 3;
  localparam int PWR_DAC_BIT     = 4;
  localparam int PWR_REF_BIT     = 5;
  localparam int REFOUT_BIT      = 6;
  localparam int FIVE_VOLT_BIT   = 7;
  localparam int IN_GAIN_LSB     = 0;
  localparam int MOD_RESET_BIT   = 3;
  localparam int OUT_GAIN_LSB    = 4;
  localparam int MUTE_BIT        = 7;
  localparam int ADVANCE_LSB     = 0;
  localparam int INTERP_BYP_BIT  = 5;
  localparam int DGT_ENABLE_BIT  = 6;

  // Timing constants, in internal master clock cycles
  localparam int         RESET_CYCLES   = 4;
  localparam logic [2:0] RESET_CNT_LAST = 3'(RESET_CYCLES - 1);
  localparam logic [2:0] DEV_ADDR_HERE  = 3'h0;
  localparam logic [11:0] SLOWEST_RATE  = 12'h800;
  localparam logic [3:0]  SLOWEST_SCLK  = 4'h8;

  // Sixteen-bit control word as it arrives from the serial port
  typedef struct packed {
    logic       is_control;
    logic       is_read;
    logic [2:0] dev_addr;
    logic [2:0] reg_addr;
    logic [7:0] data;
  } ccrb_word_t;

  // Power enables as seen by the analog sections
  typedef struct packed {
    logic analog_gain_tap_power;
    logic input_amplifier_power;
    logic adc_power;
    logic dac_power;
    logic reference_power;
    logic reference_output_enable;
    logic five_volt_mode_enable;
  } ccrb_power_t;

  // Decoded configuration fields
  typedef struct packed {
    logic       operating_mode_select;
    logic       mixed_mode_enable;
    logic       digital_loopback_enable;
    logic       serial_loopback_enable;
    logic [2:0] cascade_count;
    logic       control_echo_enable;
    logic [2:0] master_clock_divider;
    logic [1:0] serial_clock_divider;
    logic [1:0] sample_rate_divider;
    logic [2:0] input_gain_select;
    logic       modulator_reset;
    logic [2:0] output_gain_select;
    logic       output_mute;
    logic [4:0] dac_advance;
    logic       interpolator_bypass;
    logic       digital_gain_tap_enable;
  } ccrb_cfg_t;

endpackage : ccrb_pkg

/* rtl/ccrb_bank.sv */
// Codec control register bank: control word decode, storage, resets and decode
`timescale 1ns/1ps
module ccrb_bank
  import ccrb_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire ccrb_pkg::ccrb_word_t word_in,
  input  wire logic               word_in_valid,
  output ccrb_pkg::ccrb_word_t    word_out,
  output logic                    word_out_valid,
  output logic                    busy,
  output ccrb_pkg::ccrb_cfg_t     cfg,
  output ccrb_pkg::ccrb_power_t   power,
  output logic [11:0]             sample_div,
  output logic [3:0]              sclk_div
);
  import ccrb_pkg::*;

  // Reset sequencer states
  typedef enum logic [1:0] {
    CCRB_IDLE  = 2'b01,
    CCRB_RESET = 2'b10
  } ccrb_state_t;

  ccrb_state_t state;
  ccrb_state_t next_state;
  logic [2:0]  rst_cnt;
  logic [7:0]  regs [NUM_REGS];
  logic        accept;
  logic        here;
  logic        do_write;
  logic        do_read;
  logic        soft_reset_req;

  // Sample divider: code 0 slowest, each step halves the ratio
  function automatic logic [11:0] ccrb_rate_div(input logic [1:0] code);
    ccrb_rate_div = SLOWEST_RATE >> code;
  endfunction : ccrb_rate_div

  // Serial clock divider: code 0 slowest
  function automatic logic [3:0] ccrb_sclk_div(input logic [1:0] code);
    ccrb_sclk_div = SLOWEST_SCLK >> code;
  endfunction : ccrb_sclk_div

  // Write mask per register; bank holes take nothing
  function automatic logic [7:0] ccrb_wr_mask(input logic [2:0] idx);
    case (idx)
      OPERATING_MODE_CONTROL:   ccrb_wr_mask = MODE_WR_MASK;
      CONVERTER_TIMING_CONTROL: ccrb_wr_mask = TIMING_WR_MASK;
      CLOCK_RATE_CONTROL,
      POWER_CONTROL,
      GAIN_CONTROL:             ccrb_wr_mask = FULL_WR_MASK;
      default:                  ccrb_wr_mask = REG_RESET;
    endcase
  endfunction : ccrb_wr_mask

  // Control words are taken in program or mixed mode only, never while resetting
  always_comb
  begin
    accept         = word_in_valid && word_in.is_control && (state == CCRB_IDLE) &&
                     (!regs[OPERATING_MODE_CONTROL][MODE_SEL_BIT] ||
                      regs[OPERATING_MODE_CONTROL][MIXED_BIT]);
    here           = (word_in.dev_addr == DEV_ADDR_HERE);
    do_write       = accept && here && !word_in.is_read;
    do_read        = accept && here && word_in.is_read;
    soft_reset_req = do_write && (word_in.reg_addr == OPERATING_MODE_CONTROL) &&
                     word_in.data[SOFT_RESET_BIT];
  end

  // Next state of the reset sequencer
  always_comb
  begin
    case (state)
      CCRB_IDLE:  next_state = soft_reset_req ? CCRB_RESET : CCRB_IDLE;
      CCRB_RESET: next_state = (rst_cnt == RESET_CNT_LAST) ? CCRB_IDLE : CCRB_RESET;
      default:    next_state = CCRB_IDLE;
    endcase
  end

  // Sequencer state; the pin reset leaves the bank idle and cleared
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state <= CCRB_IDLE;
    else
      state <= next_state;
  end

  // Counts the four cycles of a software reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state != CCRB_RESET)
      rst_cnt <= 3'h0;
    else
      rst_cnt <= rst_cnt + 3'h1;
  end

  // Register storage; either reset clears every register
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (!rst_n || state == CCRB_RESET)
        regs[i] <= REG_RESET;
      else if (do_write && word_in.reg_addr == 3'(i))
        regs[i] <= word_in.data & ccrb_wr_mask(3'(i));
    end
  end

  assign busy = (state == CCRB_RESET);

  // Outgoing word: pass-on, read-back or echo
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      word_out       <= '0;
      word_out_valid <= 1'b0;
    end
    else
    begin
      word_out_valid <= 1'b0;
      if (accept && !here)
      begin
        word_out          <= word_in;
        word_out.dev_addr <= word_in.dev_addr - 3'h1;
        word_out_valid    <= 1'b1;
      end
      else if (do_read)
      begin
        word_out      <= word_in;
        word_out.data <= (word_in.reg_addr < 3'(NUM_REGS)) ? regs[word_in.reg_addr] : REG_RESET;
        word_out_valid <= 1'b1;
      end
      else if (do_write && regs[CLOCK_RATE_CONTROL][ECHO_BIT])
      begin
        word_out       <= word_in;
        word_out_valid <= 1'b1;
      end
    end
  end

  // Decoded mode, clock, gain and timing fields
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cfg <= '0;
    else
    begin
      cfg.operating_mode_select   <= regs[OPERATING_MODE_CONTROL][MODE_SEL_BIT];
      cfg.mixed_mode_enable       <= regs[OPERATING_MODE_CONTROL][MIXED_BIT];
      cfg.digital_loopback_enable <= regs[OPERATING_MODE_CONTROL][DLOOP_BIT];
      cfg.serial_loopback_enable  <= regs[OPERATING_MODE_CONTROL][SLOOP_BIT];
      cfg.cascade_count           <= regs[OPERATING_MODE_CONTROL][CASCADE_LSB +: 3];
      cfg.control_echo_enable     <= regs[CLOCK_RATE_CONTROL][ECHO_BIT];
      cfg.master_clock_divider    <= regs[CLOCK_RATE_CONTROL][MCLK_LSB +: 3];
      cfg.serial_clock_divider    <= regs[CLOCK_RATE_CONTROL][SCLK_LSB +: 2];
      cfg.sample_rate_divider     <= regs[CLOCK_RATE_CONTROL][RATE_LSB +: 2];
      cfg.input_gain_select       <= regs[GAIN_CONTROL][IN_GAIN_LSB +: 3];
      cfg.modulator_reset         <= regs[GAIN_CONTROL][MOD_RESET_BIT];
      cfg.output_gain_select      <= regs[GAIN_CONTROL][OUT_GAIN_LSB +: 3];
      cfg.output_mute             <= regs[GAIN_CONTROL][MUTE_BIT];
      cfg.dac_advance             <= regs[CONVERTER_TIMING_CONTROL][ADVANCE_LSB +: 5];
      cfg.interpolator_bypass     <= regs[CONVERTER_TIMING_CONTROL][INTERP_BYP_BIT];
      cfg.digital_gain_tap_enable <= regs[CONVERTER_TIMING_CONTROL][DGT_ENABLE_BIT];
    end
  end

  // Divider ratios in master clock cycles
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sample_div <= SLOWEST_RATE;
      sclk_div   <= SLOWEST_SCLK;
    end
    else
    begin
      sample_div <= ccrb_rate_div(regs[CLOCK_RATE_CONTROL][RATE_LSB +: 2]);
      sclk_div   <= ccrb_sclk_div(regs[CLOCK_RATE_CONTROL][SCLK_LSB +: 2]);
    end
  end

  // Power enables; the global bit overrides every section enable except reference output and five volt mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      power <= '0;
    else
    begin
      power.analog_gain_tap_power   <= regs[POWER_CONTROL][PWR_AGT_BIT] |
                                       regs[POWER_CONTROL][PWR_GLOBAL_BIT];
      power.input_amplifier_power   <= regs[POWER_CONTROL][PWR_IA_BIT] |
                                       regs[POWER_CONTROL][PWR_GLOBAL_BIT];
      power.adc_power               <= regs[POWER_CONTROL][PWR_ADC_BIT] |
                                       regs[POWER_CONTROL][PWR_GLOBAL_BIT];
      power.dac_power               <= regs[POWER_CONTROL][PWR_DAC_BIT] |
                                       regs[POWER_CONTROL][PWR_GLOBAL_BIT];
      power.reference_power         <= regs[POWER_CONTROL][PWR_REF_BIT] |
                                       regs[POWER_CONTROL][PWR_GLOBAL_BIT];
      power.reference_output_enable <= regs[POWER_CONTROL][REFOUT_BIT];
      power.five_volt_mode_enable   <= regs[POWER_CONTROL][FIVE_VOLT_BIT];
    end
  end

  // Steps of a software reset request
  sequence s_soft_reset_taken;
    soft_reset_req;
  endsequence

  sequence s_reset_window;
    busy [*4] ##1 !busy;
  endsequence

  chk_soft_reset_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_soft_reset_taken |-> ##1 s_reset_window)
    else $error("software reset window is not four cycles");

  chk_reset_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(busy) |-> (regs[POWER_CONTROL] == REG_RESET) && (regs[GAIN_CONTROL] == REG_RESET))
    else $error("registers not cleared by software reset");

  chk_global_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    regs[POWER_CONTROL][PWR_GLOBAL_BIT] && !busy |=> power.adc_power && power.dac_power &&
      power.input_amplifier_power && power.analog_gain_tap_power && power.reference_power)
    else $error("global power bit did not power all sections");

  chk_adc_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.adc_power == ($past(regs[POWER_CONTROL][PWR_ADC_BIT]) |
                            $past(regs[POWER_CONTROL][PWR_GLOBAL_BIT])))
    else $error("adc power enable wrong");

  chk_sample_div: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 sample_div == (SLOWEST_RATE >> $past(regs[CLOCK_RATE_CONTROL][RATE_LSB +: 2])))
    else $error("sample divider ratio wrong");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !regs[CONVERTER_TIMING_CONTROL][7] && !regs[OPERATING_MODE_CONTROL][SOFT_RESET_BIT])
    else $error("reserved or reset bit stored");

  chk_write_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_write && word_in.reg_addr == GAIN_CONTROL |=> regs[GAIN_CONTROL] == $past(word_in.data))
    else $error("gain register write lost");

  chk_mute_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_write && word_in.reg_addr == GAIN_CONTROL |-> ##2 cfg.output_mute == $past(word_in.data[MUTE_BIT], 2))
    else $error("mute does not follow gain register");

  chk_pass_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !here |=> word_out_valid && word_out.dev_addr == $past(word_in.dev_addr) - 3'h1)
    else $error("passed word not decremented");

  // Power register as the section enables see it
  logic [7:0] pwr_reg;
  assign pwr_reg = regs[POWER_CONTROL];

  // Each section follows its own bit or the global bit
  chk_agt_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.analog_gain_tap_power == $past(pwr_reg[PWR_AGT_BIT] | pwr_reg[PWR_GLOBAL_BIT]))
    else $error("gain tap power enable wrong");

  chk_ia_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.input_amplifier_power == $past(pwr_reg[PWR_IA_BIT] | pwr_reg[PWR_GLOBAL_BIT]))
    else $error("input amplifier power enable wrong");

  chk_dac_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.dac_power == $past(pwr_reg[PWR_DAC_BIT] | pwr_reg[PWR_GLOBAL_BIT]))
    else $error("dac power enable wrong");

  chk_ref_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.reference_power == $past(pwr_reg[PWR_REF_BIT] | pwr_reg[PWR_GLOBAL_BIT]))
    else $error("reference power enable wrong");

  // Reference output and supply mode follow their raw bits
  chk_refout_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.reference_output_enable == $past(pwr_reg[REFOUT_BIT]))
    else $error("reference output enable wrong");

  chk_five_volt: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 power.five_volt_mode_enable == $past(pwr_reg[FIVE_VOLT_BIT]))
    else $error("five volt mode enable wrong");

  // Gain fields reach the outputs one cycle after the register
  chk_in_gain: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.input_gain_select == $past(regs[GAIN_CONTROL][IN_GAIN_LSB +: 3]))
    else $error("input gain select wrong");

  chk_out_gain: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.output_gain_select == $past(regs[GAIN_CONTROL][OUT_GAIN_LSB +: 3]))
    else $error("output gain select wrong");

  chk_mod_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.modulator_reset == $past(regs[GAIN_CONTROL][MOD_RESET_BIT]))
    else $error("modulator reset wrong");

  // Mode and clock fields
  chk_cascade_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.cascade_count == $past(regs[OPERATING_MODE_CONTROL][CASCADE_LSB +: 3]))
    else $error("cascade count wrong");

  chk_mode_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.operating_mode_select == $past(regs[OPERATING_MODE_CONTROL][MODE_SEL_BIT]))
    else $error("operating mode select wrong");

  chk_mclk_div: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.master_clock_divider == $past(regs[CLOCK_RATE_CONTROL][MCLK_LSB +: 3]))
    else $error("master clock divider wrong");

  chk_sclk_div: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 sclk_div == (SLOWEST_SCLK >> $past(regs[CLOCK_RATE_CONTROL][SCLK_LSB +: 2])))
    else $error("serial clock divider ratio wrong");

  // Converter timing fields
  chk_dac_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.dac_advance == $past(regs[CONVERTER_TIMING_CONTROL][ADVANCE_LSB +: 5]))
    else $error("dac advance wrong");

  chk_interp_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.interpolator_bypass == $past(regs[CONVERTER_TIMING_CONTROL][INTERP_BYP_BIT]))
    else $error("interpolator bypass wrong");

  chk_dgt_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 cfg.digital_gain_tap_enable == $past(regs[CONVERTER_TIMING_CONTROL][DGT_ENABLE_BIT]))
    else $error("digital gain tap enable wrong");

  // Answers and silence on the outgoing port
  chk_echo_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_write && regs[CLOCK_RATE_CONTROL][ECHO_BIT] |=> word_out_valid && word_out == $past(word_in))
    else $error("echoed word wrong");

  chk_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_read && word_in.reg_addr == GAIN_CONTROL |=> word_out_valid && word_out.data == $past(regs[GAIN_CONTROL]))
    else $error("read back data wrong");

  chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    do_read && word_in.reg_addr >= 3'(NUM_REGS) |=> word_out_valid && word_out.data == REG_RESET)
    else $error("unmapped read not zero");

  chk_busy_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy |=> !word_out_valid)
    else $error("word answered during reset");

  chk_data_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    word_in_valid && !word_in.is_control |=> !word_out_valid)
    else $error("data word answered");

endmodule : ccrb_bank

/* tb/ccrb_dsp_model.sv */
// Behavioural DSP serial port model that issues control words and collects replies
`timescale 1ns/1ps
module ccrb_dsp_model
  import ccrb_pkg::*;
(
  input  wire logic                 core_clk,
  output ccrb_pkg::ccrb_word_t      word_in,
  output logic                      word_in_valid,
  input  wire ccrb_pkg::ccrb_word_t word_out,
  input  wire logic                 word_out_valid,
  output ccrb_pkg::ccrb_word_t      last_rx,
  output int                        rx_count
);
  // Idle port at time zero
  initial
  begin
    word_in       = '0;
    word_in_valid = 1'b0;
  end

  // Present one word after the edge; its device field picks the target
  task automatic put(input ccrb_word_t w);
    @(posedge core_clk);
    word_in       <= w;
    word_in_valid <= 1'b1;
  endtask : put

  // Release the port; released word lines show the inverse of the last word
  task automatic idle();
    @(posedge core_clk);
    word_in_valid <= 1'b0;
    word_in       <= ~word_in;
  endtask : idle

  // Collect every word sent back; one process owns the counters
  initial
  begin
    last_rx  = '0;
    rx_count = 0;
    forever
    begin
      @(posedge core_clk);
      if (word_out_valid === 1'b1)
      begin
        last_rx  <= word_out;
        rx_count <= rx_count + 1;
      end
    end
  end
endmodule : ccrb_dsp_model

/* tb/ccrb_bank_tb.sv */
// Self-checking testbench of the codec control register bank
`timescale 1ns/1ps
module ccrb_bank_tb;
  import ccrb_pkg::*;
  logic        core_clk;
  logic        rst_n;
  ccrb_word_t  word_in;
  logic        word_in_valid;
  ccrb_word_t  word_out;
  logic        word_out_valid;
  logic        busy;
  ccrb_cfg_t   cfg;
  ccrb_power_t power;
  logic [11:0] sample_div;
  logic [3:0]  sclk_div;
  ccrb_word_t  last_rx;
  int          rx_count;
  int          n_errors;
  int          samples_checked;

  ccrb_bank dut (.core_clk(core_clk), .rst_n(rst_n), .word_in(word_in), .word_in_valid(word_in_valid),
    .word_out(word_out), .word_out_valid(word_out_valid), .busy(busy), .cfg(cfg), .power(power),
    .sample_div(sample_div), .sclk_div(sclk_div));
  ccrb_dsp_model dsp (.core_clk(core_clk), .word_in(word_in), .word_in_valid(word_in_valid),
    .word_out(word_out), .word_out_valid(word_out_valid), .last_rx(last_rx), .rx_count(rx_count));

  // Clock at 25 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic ccrb_cfg_t exp_cfg(input logic [7:0] m, input logic [7:0] c, input logic [7:0] g,
    input logic [7:0] t);
    return '{m[0], m[1], m[2], m[3], m[6:4], c[7], c[6:4], c[3:2], c[1:0], g[2:0], g[3], g[6:4], g[7],
      t[4:0], t[5], t[6]};
  endfunction : exp_cfg

  function automatic logic [6:0] exp_power(input logic [7:0] d);
    return {d[1] | d[0], d[2] | d[0], d[3] | d[0], d[4] | d[0], d[5] | d[0], d[6], d[7]};
  endfunction : exp_power

  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask : settle

  task automatic hw_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : hw_reset

  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    dsp.put({1'b1, 1'b0, 3'h0, r, d});
    dsp.idle();
    settle();
  endtask : wr

  task automatic rd(input logic [2:0] r, output logic [7:0] d);
    dsp.put({1'b1, 1'b1, 3'h0, r, 8'h00});
    dsp.idle();
    settle();
    d = last_rx.data;
  endtask : rd

  task automatic t_reset_state();
    logic [7:0] d;
    int         n0;
    n0 = rx_count;
    chk("cfg", cfg, '0);
    chk("power", power, '0);
    chk("sample_div", sample_div, 12'h800);
    chk("sclk_div", sclk_div, 4'h8);
    chk("busy", busy, 1'b0);
    for (int r = 0; r < NUM_REGS; r++)
    begin
      rd(3'(r), d);
      chk("reg reset", d, 8'h00);
    end
    chk("read answers", rx_count, n0 + NUM_REGS);
  endtask : t_reset_state

  task automatic t_power();
    logic [7:0] tbl[5] = '{8'h01, 8'h3e, 8'hc0, 8'h22, 8'h00};
    foreach (tbl[i])
    begin
      wr(POWER_CONTROL, tbl[i]);
      chk("power", power, exp_power(tbl[i]));
    end
  endtask : t_power

  task automatic t_fields();
    logic [7:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      c = {1'b0, 3'(i + 3), 2'(i), 2'(i)};
      wr(CLOCK_RATE_CONTROL, c);
      chk("sample_div", sample_div, 12'h800 >> i);
      chk("sclk_div", sclk_div, 4'h8 >> i);
    end
    wr(OPERATING_MODE_CONTROL, 8'h7e);
    wr(GAIN_CONTROL, 8'hb5);
    wr(CONVERTER_TIMING_CONTROL, 8'hff);
    chk("cfg", cfg, exp_cfg(8'h7e, c, 8'hb5, 8'h7f));
    rd(CONVERTER_TIMING_CONTROL, d);
    chk("timing reg", d, 8'h7f);
    rd(OPERATING_MODE_CONTROL, d);
    chk("mode reg", d, 8'h7e);
  endtask : t_fields

  task automatic t_echo();
    int rx0;
    rx0 = rx_count;
    wr(CLOCK_RATE_CONTROL, 8'h80);
    chk("echo count", rx_count, rx0);
    wr(GAIN_CONTROL, 8'h2a);
    chk("echo count", rx_count, rx0 + 1);
    chk("echo word", last_rx, 16'h832a);
    wr(CLOCK_RATE_CONTROL, 8'h00);
    wr(GAIN_CONTROL, 8'h00);
    chk("echo count", rx_count, rx0 + 2);
  endtask : t_echo

  task automatic t_addr();
    logic [7:0] d;
    for (int r = 5; r < 8; r++)
    begin
      wr(3'(r), 8'hff);
      rd(3'(r), d);
      chk("unmapped reg", d, 8'h00);
    end
    dsp.put({1'b1, 1'b0, 3'h2, 3'h3, 8'h5a});
    dsp.idle();
    settle();
    chk("passed word", last_rx, 16'h8b5a);
    rd(GAIN_CONTROL, d);
    chk("gain reg", d, 8'h00);
  endtask : t_addr

  task automatic t_modes();
    logic [7:0] d;
    wr(OPERATING_MODE_CONTROL, 8'h03);
    wr(GAIN_CONTROL, 8'h11);
    chk("mixed write", cfg.output_gain_select, 3'h1);
    dsp.put({1'b0, 1'b0, 3'h0, 3'h3, 8'h22});
    dsp.idle();
    settle();
    rd(GAIN_CONTROL, d);
    chk("data word", d, 8'h11);
    wr(OPERATING_MODE_CONTROL, 8'h01);
    wr(GAIN_CONTROL, 8'h44);
    chk("data mode", cfg, exp_cfg(8'h01, 8'h00, 8'h11, 8'h00));
    hw_reset();
    settle();
    chk("hw reset", cfg, '0);
  endtask : t_modes

  task automatic t_soft();
    int n;
    logic [7:0] d;
    wr(GAIN_CONTROL, 8'hff);
    wr(POWER_CONTROL, 8'h3e);
    dsp.put({1'b1, 1'b0, 3'h0, OPERATING_MODE_CONTROL, 8'h80});
    dsp.put({1'b1, 1'b0, 3'h0, GAIN_CONTROL, 8'h33});
    dsp.idle();
    #1;
    n = 1;
    while (busy === 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk);
      #1;
    end
    chk("busy cycles", n, RESET_CYCLES);
    settle();
    chk("soft reset cfg", cfg, '0);
    chk("soft reset power", power, '0);
    rd(GAIN_CONTROL, d);
    chk("write while busy", d, 8'h00);
  endtask : t_soft

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    hw_reset();
    t_reset_state();
    t_power();
    t_fields();
    t_echo();
    t_addr();
    t_soft();
    t_modes();
    close_out();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    close_out();
  end
endmodule : ccrb_bank_tb
